// ### rtl/tsp_timer.sv
// 8-bit timer/counter with an 8-bit scaler shared with the watchdog, apb slave.
// assumes all inputs synchronous to MCLK_I; one instruction cycle is four clocks.
//
// Contract
// - overflow from FFh to 00h sets the overflow flag, bit 2 of interrupt_control.
// - interrupt request suppressed while enable bit 5 is clear; flag still sets.
// - counter and timer-assigned scaler stop during sleep, so overflow cannot wake the processor.
// - count path sampled on phase two and phase four of each instruction cycle.
// - external input divided by a symmetrical counter scaler ahead of the synchroniser.
// - counter increments only after the synchroniser has captured the edge.
// - one 8-bit scaler serves either the timer or the watchdog, never both.
// - timer-assigned scaler leaves watchdog unscaled; watchdog-assigned leaves timer unscaled.
// - assignment and 3-bit ratio come from option bits 3:0, bit 3 assignment.
// - timer-assigned scaler cleared by every write to the counter register.
// - watchdog-assigned scaler cleared with the watchdog by watchdog_clear_op.
// - scaler count neither readable nor writable by software.
// - scaler assignment may change at any time without reset.
// - counter undefined at power-on, unchanged through all other resets.
// - timer mode counts each instruction cycle; two cycles skipped after a write.
// - counter mode: rising edges when edge select clear, falling when set.
// - timer-assigned scaler ratios 1:2 up to 1:256 by the ratio field.
`timescale 1ns/1ns
`default_nettype none

module tsp_timer
  import tsp_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        EXT_COUNT_INPUT_I,
  input  wire logic        SLEEP_I,
  input  wire logic        WATCHDOG_CLEAR_OP_I,
  input  wire logic        WATCHDOG_TICK_I,
  output logic             WATCHDOG_TICK_O,
  output logic             OVERFLOW_IRQ_O,
  output logic      [7:0]  OPTION_O,
  output logic      [5:0]  PIN_DIRECTION_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  timer_count_reg;
  logic [7:0]  int_control_reg;
  logic [7:0]  option_reg;
  logic [5:0]  pin_dir_reg;
  logic [7:0]  scaler_reg;
  logic [1:0]  inhibit_reg;
  logic        ext_prev_reg;
  logic        sample_reg;
  logic        rise_reg;
  tsp_phase_t  phase_reg;
  tsp_phase_t  phase_next;
  tsp_option_t opt;

  logic        acc;
  logic        wr;
  logic        wr_count;
  logic        wr_intc;
  logic        timer_owns;
  logic        ext_level;
  logic        ext_edge;
  logic        scaler_step;
  logic        pre_out;
  logic        sample_now;
  logic        count_inc;
  logic        overflow;
  logic        hit;

  // divide mask: ratio n keeps n+1 low bits
  function automatic logic [7:0] ratio_mask(input logic [2:0] n);
    ratio_mask = 8'hFF >> (3'h7 - n);
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign opt        = tsp_option_t'(option_reg);
  assign acc        = PSEL_I && PENABLE_I && PREADY_O;
  assign wr         = acc && PWRITE_I;
  assign wr_count   = wr && (PADDR_I == `TSP_A_TIMER_COUNT);
  assign wr_intc    = wr && (PADDR_I == `TSP_A_INT_CONTROL);
  assign hit        = (PADDR_I == `TSP_A_TIMER_COUNT) || (PADDR_I == `TSP_A_INT_CONTROL) ||
                      (PADDR_I == `TSP_A_OPTION_CONFIG) || (PADDR_I == `TSP_A_PIN_DIRECTION);
  assign timer_owns = !opt.scaler_assign;

  // ----------------------------------------------------------------
  // phase sequencer: four clocks per instruction cycle
  // ----------------------------------------------------------------
  always_comb begin
    case (phase_reg)
      TSP_PH_ONE:   phase_next = TSP_PH_TWO;
      TSP_PH_TWO:   phase_next = TSP_PH_THREE;
      TSP_PH_THREE: phase_next = TSP_PH_FOUR;
      TSP_PH_FOUR:  phase_next = TSP_PH_ONE;
      default:      phase_next = TSP_PH_ONE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      phase_reg <= TSP_PH_ONE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // count source and scaler
  // ----------------------------------------------------------------
  // edge select inverts the pin so the wanted edge always rises
  assign ext_level = EXT_COUNT_INPUT_I ^ opt.count_edge_select;
  assign ext_edge  = ext_level && !ext_prev_reg;
  // one scaler, stepped by whichever side owns it
  assign scaler_step = timer_owns ?
                       (!SLEEP_I && (opt.count_source_select ? ext_edge : (phase_reg == TSP_PH_FOUR))) :
                       WATCHDOG_TICK_I;
  // ratio field picks the scaler stage
  // symmetrical divider output; bit n falls once per 2^(n+1) steps
  // inverted so the carry, not the half-way point, gives the rising edge:
  // a freshly cleared scaler waits a full ratio before its first count
  always_comb begin
    if (!timer_owns) begin
      pre_out = opt.count_source_select ? ext_level : 1'b0;
    end else begin
      pre_out = !scaler_reg[opt.scale_ratio];
    end
  end
  // synchroniser samples on phase two and four
  assign sample_now = (phase_reg == TSP_PH_TWO) || (phase_reg == TSP_PH_FOUR);

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      // follow the pin during reset so release raises no false edge
      ext_prev_reg <= ext_level;
    end else begin
      ext_prev_reg <= ext_level;
    end
  end

  // scaler hidden from bus
  // scaler: no bus path reaches it, so software cannot read or load it
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      scaler_reg <= 8'h00;
    end else if (timer_owns && wr_count) begin
      scaler_reg <= 8'h00;
    end else if (!timer_owns && WATCHDOG_CLEAR_OP_I) begin
      scaler_reg <= 8'h00;
    end else if (scaler_step) begin
      scaler_reg <= scaler_reg + 8'h01;
    end
  end

  // watchdog gets raw ticks unless it owns the scaler
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      WATCHDOG_TICK_O <= 1'b0;
    end else if (timer_owns) begin
      WATCHDOG_TICK_O <= WATCHDOG_TICK_I;
    end else begin
      WATCHDOG_TICK_O <= WATCHDOG_TICK_I &&
                         ((scaler_reg & ratio_mask(opt.scale_ratio)) == ratio_mask(opt.scale_ratio));
    end
  end

  // sampled rise, one cycle after capture, drives the count
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      // start at the present level, else an idle-high source counts once after reset
      sample_reg <= pre_out;
      rise_reg   <= 1'b0;
    end else if (sample_now) begin
      sample_reg <= pre_out;
      rise_reg   <= pre_out && !sample_reg;
    end else begin
      rise_reg   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // counter increment
  // ----------------------------------------------------------------
  // unscaled timer mode steps at phase four; frozen in sleep
  always_comb begin
    if (SLEEP_I || inhibit_reg != 2'h0) begin
      count_inc = 1'b0;
    end else if (!timer_owns && !opt.count_source_select) begin
      count_inc = (phase_reg == TSP_PH_FOUR);
    end else begin
      count_inc = rise_reg;
    end
  end
  assign overflow = count_inc && !wr_count && (timer_count_reg == `TSP_COUNT_MAX);

  // two instruction cycles without increment after a write
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      inhibit_reg <= 2'h0;
    end else if (wr_count) begin
      inhibit_reg <= `TSP_INHIBIT_CYCLES;
    end else if (phase_reg == TSP_PH_FOUR && inhibit_reg != 2'h0) begin
      inhibit_reg <= inhibit_reg - 2'h1;
    end
  end

  // no reset term: value kept through resets, unknown at power-on
  always_ff @(posedge MCLK_I) begin
    if (wr_count) begin
      timer_count_reg <= PWDATA_I[7:0];
    end else if (count_inc) begin
      timer_count_reg <= timer_count_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // overflow sets flag, and wins over a software clear; never self-clears
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      int_control_reg <= `TSP_RST_INT_CONTROL;
    end else begin
      if (wr_intc) begin
        int_control_reg <= PWDATA_I[7:0];
      end
      if (overflow) begin
        int_control_reg[`TSP_BIT_OVF_FLAG] <= 1'b1;
      end
    end
  end

  // assignment writable at any time, takes effect next cycle
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      option_reg  <= `TSP_RST_OPTION;
      pin_dir_reg <= `TSP_RST_PIN_DIR;
    end else if (wr && PADDR_I == `TSP_A_OPTION_CONFIG) begin
      option_reg  <= PWDATA_I[7:0];
    end else if (wr && PADDR_I == `TSP_A_PIN_DIRECTION) begin
      pin_dir_reg <= PWDATA_I[5:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      OVERFLOW_IRQ_O  <= 1'b0;
      OPTION_O        <= `TSP_RST_OPTION;
      PIN_DIRECTION_O <= `TSP_RST_PIN_DIR;
    end else begin
      OVERFLOW_IRQ_O  <= int_control_reg[`TSP_BIT_OVF_FLAG] && int_control_reg[`TSP_BIT_OVF_IRQ_EN];
      OPTION_O        <= option_reg;
      PIN_DIRECTION_O <= pin_dir_reg;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: data captured in setup, ready for one access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I) begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= !hit;
      case (PADDR_I)
        `TSP_A_TIMER_COUNT:   PRDATA_O <= {24'h000000, timer_count_reg};
        `TSP_A_INT_CONTROL:   PRDATA_O <= {24'h000000, int_control_reg};
        `TSP_A_OPTION_CONFIG: PRDATA_O <= {24'h000000, option_reg};
        `TSP_A_PIN_DIRECTION: PRDATA_O <= {26'h0, pin_dir_reg};
        default:              PRDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_count_write;
    wr_count;
  endsequence

  sequence s_quiet_count;
    !count_inc [*4];
  endsequence

  a_overflow_sets_flag: assert property (overflow |=> int_control_reg[`TSP_BIT_OVF_FLAG])
    else $error("overflow did not set flag");
  a_irq_mask_gate: assert property (!int_control_reg[`TSP_BIT_OVF_IRQ_EN] |=> !OVERFLOW_IRQ_O)
    else $error("masked overflow raised request");
  a_sleep_freezes_count: assert property ((SLEEP_I && !wr_count) |=> $stable(timer_count_reg))
    else $error("counter moved in sleep");
  a_sample_on_phase: assert property ($rose(rise_reg) |-> $past(phase_reg) == TSP_PH_TWO ||
                                      $past(phase_reg) == TSP_PH_FOUR)
    else $error("sample outside phase two or four");
  a_write_clears_scaler: assert property ((wr_count && timer_owns) |=> scaler_reg == 8'h00)
    else $error("counter write left scaler");
  a_wdclear_scaler: assert property ((WATCHDOG_CLEAR_OP_I && !timer_owns) |=> scaler_reg == 8'h00)
    else $error("watchdog clear left scaler");
  a_write_inhibit: assert property (s_count_write |=> s_quiet_count)
    else $error("count moved right after write");
  a_count_after_sync: assert property ((count_inc && !wr_count) |=>
                                       timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("increment lost");
  a_wd_unscaled: assert property ((timer_owns && WATCHDOG_TICK_I) |=> WATCHDOG_TICK_O)
    else $error("watchdog tick scaled while timer owns scaler");

  // flag, request, sleep and option checks
  a_flag_sticky: assert property ((int_control_reg[`TSP_BIT_OVF_FLAG] && !wr_intc) |=>
                                  int_control_reg[`TSP_BIT_OVF_FLAG])
    else $error("flag cleared without a write");
  a_irq_follows_flag: assert property ((int_control_reg[`TSP_BIT_OVF_FLAG] && int_control_reg[`TSP_BIT_OVF_IRQ_EN])
                                       |=> OVERFLOW_IRQ_O)
    else $error("enabled flag raised no request");
  a_sleep_holds_scaler: assert property ((SLEEP_I && timer_owns && !wr_count) |=> $stable(scaler_reg))
    else $error("timer-side scaler moved in sleep");
  a_option_write_lands: assert property ((wr && PADDR_I == `TSP_A_OPTION_CONFIG) |=>
                                         option_reg == $past(PWDATA_I[7:0]))
    else $error("option write did not land");

endmodule

`default_nettype wire

// ### rtl/tsp_consts.svh
// constants for the timer with shared scaler: register indices, byte addresses,
// field positions, reset values and timing counts.
// assumes inclusion by bare name from the package and the design files.
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// ----------------------------------------------------------------
// register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define TSP_IDX_TIMER_COUNT   8'h01
`define TSP_IDX_INT_CONTROL   8'h0B
`define TSP_IDX_OPTION_CONFIG 8'h81
`define TSP_IDX_PIN_DIRECTION 8'h85
`define TSP_ADDR_W            12
`define TSP_A_TIMER_COUNT     {2'b00, `TSP_IDX_TIMER_COUNT, 2'b00}
`define TSP_A_INT_CONTROL     {2'b00, `TSP_IDX_INT_CONTROL, 2'b00}
`define TSP_A_OPTION_CONFIG   {2'b00, `TSP_IDX_OPTION_CONFIG, 2'b00}
`define TSP_A_PIN_DIRECTION   {2'b00, `TSP_IDX_PIN_DIRECTION, 2'b00}

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TSP_BIT_OVF_FLAG      2
`define TSP_BIT_OVF_IRQ_EN    5

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define TSP_RST_INT_CONTROL   8'h00
`define TSP_RST_OPTION        8'hFF
`define TSP_RST_PIN_DIR       6'h3F
`define TSP_COUNT_MAX         8'hFF
`define TSP_INHIBIT_CYCLES    2'h2

`endif

// ### rtl/tsp_pkg.sv
// types for the timer with shared scaler.
// assumes tsp_consts.svh is on the include path.
package tsp_pkg;
  `include "tsp_consts.svh"

  // option register fields, msb first
  typedef struct packed {
    logic       pull_up_off;
    logic       int_edge;
    logic       count_source_select;
    logic       count_edge_select;
    logic       scaler_assign;
    logic [2:0] scale_ratio;
  } tsp_option_t;

  // one-hot phase of the instruction cycle
  typedef enum logic [3:0] {
    TSP_PH_ONE   = 4'b0001,
    TSP_PH_TWO   = 4'b0010,
    TSP_PH_THREE = 4'b0100,
    TSP_PH_FOUR  = 4'b1000
  } tsp_phase_t;
endpackage

// ### tb/tsp_ext_src.sv
// count source model standing on the external count input pin.
// assumes the bench calls its tasks; the line moves just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module tsp_ext_src #(
  parameter int HOLD = 4
) (
  input  wire logic clk_i,
  output logic      cnt_o
);
  // ----------------------------------------------------------------
  // level stepping
  // ----------------------------------------------------------------
  // line starts low so the first step is a clean rising edge
  initial cnt_o = 1'b0;

  // minimum level width
  // each level held HOLD clocks, so sampling on phase two or four never misses it
  task automatic step(input logic v);
    @(posedge clk_i) cnt_o <= v;
    repeat (HOLD - 1) @(posedge clk_i);
  endtask

  // whole pulses, line left low afterwards
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      step(1'b1);
      step(1'b0);
    end
  endtask
endmodule

`default_nettype wire

// ### tb/tsp_timer_tb.sv
// self-checking bench for the timer with shared scaler, apb master and count source.
// assumes tsp_pkg, tsp_timer and tsp_ext_src are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "tsp_consts.svh"

module tsp_timer_tb
  import tsp_pkg::*;
();
  localparam logic [11:0] a_cnt = `TSP_A_TIMER_COUNT;
  localparam logic [11:0] a_int = `TSP_A_INT_CONTROL;
  localparam logic [11:0] a_opt = `TSP_A_OPTION_CONFIG;
  localparam logic [11:0] a_pin = `TSP_A_PIN_DIRECTION;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic        sleep, wd_clr, wd_tick, wd_tick_out, irq, ext_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  option;
  logic [5:0]  pin_dir;
  int          err_count, samples_checked, cycles, wd_seen;

  tsp_timer uut (
    .MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_COUNT_INPUT_I(ext_in),
    .SLEEP_I(sleep), .WATCHDOG_CLEAR_OP_I(wd_clr), .WATCHDOG_TICK_I(wd_tick),
    .WATCHDOG_TICK_O(wd_tick_out), .OVERFLOW_IRQ_O(irq), .OPTION_O(option),
    .PIN_DIRECTION_O(pin_dir)
  );
  tsp_ext_src src (.clk_i(mclk), .cnt_o(ext_in));

  // ----------------------------------------------------------------
  // clock, timeout and watchdog tick monitor
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // pre-edge sampling, so each one-cycle tick is counted once
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (wd_tick_out === 1'b1) wd_seen = wd_seen + 1;
    if (cycles == 40000) begin
      fail("timeout");
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // bus, stimulus and compare tasks
  // ----------------------------------------------------------------
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic do_reset();
    @(posedge mclk) rst_b <= 1'b0;
    clk(10);
    rst_b <= 1'b1;
  endtask
  task automatic fail(input string m);
    err_count = err_count + 1;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) fail(m);
  endtask
  // an unknown value never lands inside the range
  task automatic chk_rng(input string m, input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked = samples_checked + 1;
    if ((got >= lo && got <= hi) !== 1'b1) fail(m);
  endtask
  // request held until pready is seen high at a rising edge, no cycle count assumed
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string m);
    xfer(1'b0, a, 32'h0);
    chk(m, rd, {24'h0, exp});
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk) wd_tick <= 1'b1;
      @(posedge mclk) wd_tick <= 1'b0;
      clk(2);
    end
    clk(3);
  endtask
  task automatic wclr();
    @(posedge mclk) wd_clr <= 1'b1;
    @(posedge mclk) wd_clr <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {err_count, samples_checked, cycles, wd_seen} = '0;
    {rst_b, psel, penable, pwrite, sleep, wd_clr, wd_tick} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    do_reset();
    // counter is unknown at power-on: give it a value before anything counts
    wr(a_cnt, 8'h00);
    // reset values, unmapped place, narrow register
    rd_chk(a_opt, 8'hFF, "option reset");
    chk("option port", {24'h0, option}, 32'h0000_00FF);
    rd_chk(a_int, 8'h00, "interrupt_control reset");
    rd_chk(12'h3FC, 8'h00, "unmapped data");
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    wr(a_pin, 8'hFF);
    rd_chk(a_pin, 8'h3F, "pin dir width");
    chk("pin port", {26'h0, pin_dir}, 32'h0000_003F);
    // timer mode unscaled, write inhibit of two instruction cycles
    wr(a_opt, 8'h08);
    wr(a_cnt, 8'h10);
    rd_chk(a_cnt, 8'h10, "inhibit early");
    clk(40);
    xfer(1'b0, a_cnt, 32'h0);
    chk_rng("inhibit rate", rd, 32'h0000_0018, 32'h0000_001A);
    // overflow flag and masked request
    wr(a_int, 8'h00);
    wr(a_cnt, 8'hFF);
    clk(12);
    rd_chk(a_int, 8'h04, "flag set");
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(a_int, 8'h20);
    clk(2);
    chk("irq after clear", {31'h0, irq}, 32'h0000_0000);
    wr(a_cnt, 8'hFF);
    clk(14);
    chk("irq enabled", {31'h0, irq}, 32'h0000_0001);
    clk(40);
    rd_chk(a_int, 8'h24, "flag sticky");
    wr(a_int, 8'h00);
    // sleep freezes the count, no overflow
    sleep <= 1'b1;
    wr(a_cnt, 8'hFF);
    clk(40);
    rd_chk(a_cnt, 8'hFF, "sleep count");
    rd_chk(a_int, 8'h00, "sleep flag");
    // count survives a later reset; option returns to counter mode
    wr(a_cnt, 8'h5A);
    do_reset();
    sleep <= 1'b0;
    rd_chk(a_cnt, 8'h5A, "count kept");
    rd_chk(a_opt, 8'hFF, "option again");
    // edge select, unscaled counter mode
    for (int es = 0; es < 2; es++) begin
      wr(a_opt, 8'h28 | 8'(es << 4));
      wr(a_cnt, 8'h00);
      clk(10);
      src.step(1'b1);
      rd_chk(a_cnt, {7'h0, es == 0}, "after rise");
      src.step(1'b0);
      rd_chk(a_cnt, 8'h01, "after fall");
    end
    // every ratio: one count per 2^(n+1) edges
    for (int n = 0; n < 8; n++) begin
      wr(a_opt, 8'h20 | n[7:0]);
      wr(a_cnt, 8'h00);
      clk(10);
      src.pulses((2 << n) - 1);
      clk(4);
      rd_chk(a_cnt, 8'h00, "ratio short");
      src.pulses(1);
      clk(4);
      rd_chk(a_cnt, 8'h01, "ratio full");
    end
    // counter write clears the timer-side scaler
    wr(a_opt, 8'h21);
    wr(a_cnt, 8'h00);
    src.pulses(3);
    wr(a_cnt, 8'h00);
    src.pulses(3);
    clk(4);
    rd_chk(a_cnt, 8'h00, "scaler cleared");
    // timer mode through the scaler at 1:2: one count per two instruction cycles
    wr(a_opt, 8'h00);
    wr(a_cnt, 8'h00);
    clk(64);
    xfer(1'b0, a_cnt, 32'h0);
    chk_rng("scaled timer", rd, 32'h0000_0007, 32'h0000_0008);
    // watchdog ticks pass unscaled while the timer owns the scaler
    wd_seen = 0;
    ticks(8);
    chk("wd unscaled", 32'(wd_seen), 32'h0000_0008);
    wr(a_cnt, 8'h00);
    wclr();
    wr(a_opt, 8'h0B);
    wd_seen = 0;
    ticks(32);
    chk("wd scaled", 32'(wd_seen), 32'h0000_0002);
    // clear op restarts the watchdog-side scaler each time
    wclr();
    wd_seen = 0;
    repeat (8) begin
      ticks(1);
      wclr();
    end
    chk("wd cleared", 32'(wd_seen), 32'h0000_0000);
    // back to the timer: clear the watchdog side, then option bit 3 low
    wclr();
    wr(a_opt, 8'h20);
    wr(a_cnt, 8'h00);
    clk(10);
    src.pulses(2);
    clk(4);
    rd_chk(a_cnt, 8'h01, "back to timer");
    give_verdict();
  end
endmodule

`default_nettype wire
